// ---- rtl/lcd_consts.svh ----
// constants for the literal and control instruction decoder
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH

// wishbone register byte offsets
`define LCD_REG_CTRL 8'h00
`define LCD_REG_STATUS 8'h04
`define LCD_REG_PC 8'h08
`define LCD_REG_PAGE 8'h0c

// control register fields
`define LCD_CTRL_RUN 0
`define LCD_CTRL_PSA_T0 1
`define LCD_CTRL_WAKE 2

// status register fields
`define LCD_ST_C 8
`define LCD_ST_DIGIT 9
`define LCD_ST_Z 10
`define LCD_ST_TIMEOUT 11
`define LCD_ST_POWERDOWN 12
`define LCD_ST_STBY 13

// reset values
`define LCD_CTRL_RST 2'h0
`define LCD_PC_RST 13'h0000
`define LCD_PAGE_RST 5'h00
`define LCD_W_RST 8'h00

// fixed control words
`define LCD_WORD_WDT_CLR 14'h0064
`define LCD_WORD_SLEEP 14'h0063
`define LCD_WORD_IRQ_RET 14'h0009
`define LCD_WORD_RETURN 14'h0008

// opcode fields
`define LCD_CLS_FILE 2'h0
`define LCD_CLS_BIT 2'h1
`define LCD_CLS_JUMP 2'h2
`define LCD_CLS_LIT 2'h3
`define LCD_OPF_ADD_FILE 4'h7
`define LCD_OPL_IOR 4'h8
`define LCD_OPL_AND 4'h9
`define LCD_OPL_XOR 4'ha
`define LCD_OPL_MOV 2'h0
`define LCD_OPL_RET 2'h1
`define LCD_OPL_SUB 3'h6
`define LCD_OPL_ADD 3'h7
`define LCD_OPB_CLR 2'h0
`define LCD_OPB_SET 2'h1

// special file register addresses
`define LCD_ADDR_TIMER0 7'h01
`define LCD_ADDR_PORT 7'h06

`endif

// ---- rtl/lcd_pkg.sv ----
// types shared by the decoder and its arithmetic unit
package lcd_pkg;

    // arithmetic unit operations
    typedef enum logic [3:0] {
        LCD_ALU_ADD,
        LCD_ALU_SUBL,
        LCD_ALU_AND,
        LCD_ALU_OR,
        LCD_ALU_XOR,
        LCD_ALU_PASS,
        LCD_ALU_BSET,
        LCD_ALU_BCLR
    } lcd_alu_op_t;

    // decoded instruction kinds
    typedef enum logic [3:0] {
        LCD_K_NOP,
        LCD_K_LIT,
        LCD_K_FILE,
        LCD_K_BIT,
        LCD_K_CALL,
        LCD_K_JUMP,
        LCD_K_RET,
        LCD_K_RETLIT,
        LCD_K_IRQRET,
        LCD_K_WDT,
        LCD_K_SLEEP
    } lcd_kind_t;

    // sequencer states
    typedef enum logic [1:0] {
        LCD_ST_EXEC,
        LCD_ST_FLUSH,
        LCD_ST_STANDBY
    } lcd_state_t;

endpackage

// ---- rtl/lcd_alu_if.sv ----
// link between the decoder and its arithmetic unit
`timescale 1ns/100ps
interface lcd_alu_if;
    import lcd_pkg::*;
    lcd_alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic [2:0] bit_sel;
    logic [7:0] y;
    logic c;
    logic digit_c;
    logic z;
    modport core (output op, a, b, bit_sel, input y, c, digit_c, z);
    modport alu (input op, a, b, bit_sel, output y, c, digit_c, z);
endinterface

// ---- rtl/lcd_alu.sv ----
// combinational arithmetic and bit unit
`timescale 1ns/100ps
module lcd_alu
    import lcd_pkg::*;
(
    lcd_alu_if.alu io // operands in, result and flags out
);
    logic [8:0] sum;
    logic [4:0] nib;

    // carry is carry-out, for subtract a set carry means no borrow
    always_comb begin
        sum = 9'h000;
        nib = 5'h00;
        io.y = io.b;
        io.c = 1'b0;
        io.digit_c = 1'b0;
        case (io.op)
            LCD_ALU_ADD: begin
                sum = {1'b0, io.a} + {1'b0, io.b};
                nib = {1'b0, io.a[3:0]} + {1'b0, io.b[3:0]};
                io.y = sum[7:0];
                io.c = sum[8];
                io.digit_c = nib[4];
            end
            LCD_ALU_SUBL: begin
                sum = {1'b0, io.b} + {1'b0, ~io.a} + 9'h001;
                nib = {1'b0, io.b[3:0]} + {1'b0, ~io.a[3:0]} + 5'h01;
                io.y = sum[7:0];
                io.c = sum[8];
                io.digit_c = nib[4];
            end
            LCD_ALU_AND: io.y = io.a & io.b;
            LCD_ALU_OR: io.y = io.a | io.b;
            LCD_ALU_XOR: io.y = io.a ^ io.b;
            LCD_ALU_PASS: io.y = io.b;
            LCD_ALU_BSET: io.y = io.b | (8'h01 << io.bit_sel);
            LCD_ALU_BCLR: io.y = io.b & ~(8'h01 << io.bit_sel);
            default: io.y = io.b;
        endcase
        io.z = (io.y == 8'h00);
    end
endmodule

// ---- rtl/lcd_core.sv ----
// literal and control instruction decoder with execute control
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "lcd_consts.svh"

// Summary of operation
// - and literal into working register, zero only
// - watchdog clear word resets watchdog, sets flags
// - or literal into working register, zero only
// - interrupt return pops stack in two cycles
// - return with literal loads w, two cycles
// - plain return pops stack in two cycles
// - standby word enters standby, updates flags
// - literal minus w, carry digit zero
// - xor literal into working register, zero only
// - port read-modify-write uses pin levels
// - timer zero write clears assigned prescaler
// - program counter change costs a second cycle
// - add literal to w, carry digit zero
// - bit clear forces file bit low
// - bit set forces file bit high
// - add file, destination bit picks target
// - call pushes return, loads paged target
module lcd_core
    import lcd_pkg::*;
#(
    parameter int STACK_DEPTH = 8,
    parameter int FILE_WORDS = 128
) (
    input wire logic clk_i, // 40 MHz core clock
    input wire logic rst_i, // synchronous reset, active high
    input wire logic [13:0] instr_i, // instruction word at pc_o
    input wire logic instr_valid_i, // instruction word present
    input wire logic [7:0] port_pins_i, // sampled port pin levels
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write enable
    input wire logic [7:0] wb_adr_i, // wishbone byte address
    input wire logic [31:0] wb_dat_i, // wishbone write data
    input wire logic [3:0] wb_sel_i, // wishbone byte selects
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    output logic [12:0] pc_o, // program counter
    output logic [7:0] port_latch_o, // port output latch
    output logic standby_o, // core is in standby
    output logic wdt_clear_o, // pulse: clear watchdog and its prescaler
    output logic presc_clear_o, // pulse: clear timer zero prescaler
    output logic irq_return_o // pulse: interrupt return executed
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    lcd_alu_if alu_bus ();

    lcd_state_t state_q;
    logic [1:0] ctrl_q;
    logic [4:0] page_q;
    logic [7:0] w_q;
    logic c_q;
    logic digit_q;
    logic z_q;
    logic timeout_q;
    logic powerdown_q;
    logic [12:0] stack_mem [STACK_DEPTH];
    logic [SP_W-1:0] sp_q;
    logic [7:0] file_mem [FILE_WORDS];

    lcd_kind_t kind;
    lcd_alu_op_t alu_op;
    logic [6:0] f_addr;
    logic dest_file;
    logic [7:0] file_rd;
    logic go;
    logic file_we;
    logic [12:0] pc_inc;
    logic [12:0] pc_pop;
    logic wb_req;
    logic wb_wr;
    logic wake;

    ////////////////////////////////////////////////////////////////////
    // arithmetic unit
    lcd_alu u_alu (
        .io (alu_bus)
    );

    ////////////////////////////////////////////////////////////////////
    // decode of the instruction word
    assign f_addr = instr_i[6:0];
    assign dest_file = instr_i[7];

    always_comb begin
        kind = LCD_K_NOP;
        alu_op = LCD_ALU_PASS;
        case (instr_i[13:12])
            `LCD_CLS_LIT: begin
                if (instr_i[11:10] == `LCD_OPL_MOV) begin
                    kind = LCD_K_LIT;
                end else if (instr_i[11:10] == `LCD_OPL_RET) begin
                    kind = LCD_K_RETLIT;
                end else if (instr_i[11:8] == `LCD_OPL_IOR) begin
                    kind = LCD_K_LIT;
                    alu_op = LCD_ALU_OR;
                end else if (instr_i[11:8] == `LCD_OPL_AND) begin
                    kind = LCD_K_LIT;
                    alu_op = LCD_ALU_AND;
                end else if (instr_i[11:8] == `LCD_OPL_XOR) begin
                    kind = LCD_K_LIT;
                    alu_op = LCD_ALU_XOR;
                end else if (instr_i[11:9] == `LCD_OPL_SUB) begin
                    kind = LCD_K_LIT;
                    alu_op = LCD_ALU_SUBL;
                end else if (instr_i[11:9] == `LCD_OPL_ADD) begin
                    kind = LCD_K_LIT;
                    alu_op = LCD_ALU_ADD;
                end
            end
            `LCD_CLS_JUMP: begin
                kind = instr_i[11] ? LCD_K_JUMP : LCD_K_CALL;
            end
            `LCD_CLS_BIT: begin
                if (instr_i[11:10] == `LCD_OPB_CLR) begin
                    kind = LCD_K_BIT;
                    alu_op = LCD_ALU_BCLR;
                end else if (instr_i[11:10] == `LCD_OPB_SET) begin
                    kind = LCD_K_BIT;
                    alu_op = LCD_ALU_BSET;
                end
            end
            default: begin
                if (instr_i == `LCD_WORD_WDT_CLR) begin
                    kind = LCD_K_WDT;
                end else if (instr_i == `LCD_WORD_SLEEP) begin
                    kind = LCD_K_SLEEP;
                end else if (instr_i == `LCD_WORD_IRQ_RET) begin
                    kind = LCD_K_IRQRET;
                end else if (instr_i == `LCD_WORD_RETURN) begin
                    kind = LCD_K_RET;
                end else if (instr_i[11:8] == `LCD_OPF_ADD_FILE) begin
                    kind = LCD_K_FILE;
                    alu_op = LCD_ALU_ADD;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // operand routing
    // port pins as source
    assign file_rd = (f_addr == `LCD_ADDR_PORT) ? port_pins_i : file_mem[f_addr];

    assign alu_bus.op = alu_op;
    assign alu_bus.a = w_q;
    assign alu_bus.b = (kind == LCD_K_FILE || kind == LCD_K_BIT) ? file_rd : instr_i[7:0];
    assign alu_bus.bit_sel = instr_i[9:7];

    // execution only while running and awake with a word present
    assign go = ctrl_q[`LCD_CTRL_RUN] && (state_q == LCD_ST_EXEC) && instr_valid_i;
    assign file_we = go && ((kind == LCD_K_BIT) || (kind == LCD_K_FILE && dest_file));
    assign pc_inc = pc_o + 13'h0001;
    assign pc_pop = stack_mem[sp_q - SP_W'(1)];

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `LCD_REG_CTRL);
    assign wake = wb_wr && wb_dat_i[`LCD_CTRL_WAKE];

    ////////////////////////////////////////////////////////////////////
    // sequencer: execute, dummy second cycle, standby
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= LCD_ST_EXEC;
        end else begin
            case (state_q)
                LCD_ST_EXEC: begin
                    if (go) begin
                        if (kind == LCD_K_CALL || kind == LCD_K_JUMP || kind == LCD_K_RET ||
                            kind == LCD_K_RETLIT || kind == LCD_K_IRQRET) begin
                            state_q <= LCD_ST_FLUSH;
                        end else if (kind == LCD_K_SLEEP) begin
                            state_q <= LCD_ST_STANDBY;
                        end
                    end
                end
                LCD_ST_FLUSH: state_q <= LCD_ST_EXEC;
                LCD_ST_STANDBY: begin
                    if (wake) begin
                        state_q <= LCD_ST_EXEC;
                    end
                end
                default: state_q <= LCD_ST_EXEC;
            endcase
        end
    end

    // standby flag mirrors the state as a plain flop for the pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            standby_o <= 1'b0;
        end else if (go && kind == LCD_K_SLEEP) begin
            standby_o <= 1'b1;
        end else if (state_q == LCD_ST_STANDBY && wake) begin
            standby_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // program counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_o <= `LCD_PC_RST;
        end else if (go) begin
            case (kind)
                LCD_K_CALL, LCD_K_JUMP: pc_o <= {page_q[4:3], instr_i[10:0]};
                LCD_K_RET, LCD_K_RETLIT, LCD_K_IRQRET: pc_o <= pc_pop;
                default: pc_o <= pc_inc;
            endcase
        end
    end

    // return stack: a circular buffer, overflow wraps silently
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp_q <= '0;
        end else if (go) begin
            if (kind == LCD_K_CALL) begin
                stack_mem[sp_q] <= pc_inc;
                sp_q <= sp_q + SP_W'(1);
            end else if (kind == LCD_K_RET || kind == LCD_K_RETLIT || kind == LCD_K_IRQRET) begin
                sp_q <= sp_q - SP_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // working register and arithmetic flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            w_q <= `LCD_W_RST;
        end else if (go) begin
            if (kind == LCD_K_LIT || kind == LCD_K_RETLIT) begin
                w_q <= (kind == LCD_K_RETLIT) ? instr_i[7:0] : alu_bus.y;
            // sum to w when d clear
            end else if (kind == LCD_K_FILE && !dest_file) begin
                w_q <= alu_bus.y;
            end
        end
    end

    // flags: logic ops touch zero only, adds and subtracts all three
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c_q <= 1'b0;
            digit_q <= 1'b0;
            z_q <= 1'b0;
        end else if (go && (kind == LCD_K_LIT || kind == LCD_K_FILE)) begin
            if (alu_op != LCD_ALU_PASS) begin
                z_q <= alu_bus.z;
            end
            if (alu_op == LCD_ALU_ADD || alu_op == LCD_ALU_SUBL) begin
                c_q <= alu_bus.c;
                digit_q <= alu_bus.digit_c;
            end
        end
    end

    // timeout and power-down bits, both high after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timeout_q <= 1'b1;
            powerdown_q <= 1'b1;
        end else if (go) begin
            if (kind == LCD_K_WDT) begin
                timeout_q <= 1'b1;
                powerdown_q <= 1'b1;
            end else if (kind == LCD_K_SLEEP) begin
                timeout_q <= 1'b1;
                powerdown_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // file registers and port latch
    // bit written back to file
    always_ff @(posedge clk_i) begin
        if (file_we) begin
            file_mem[f_addr] <= alu_bus.y;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_latch_o <= 8'h00;
        end else if (file_we && f_addr == `LCD_ADDR_PORT) begin
            port_latch_o <= alu_bus.y;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // one-cycle side pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_clear_o <= 1'b0;
            presc_clear_o <= 1'b0;
            irq_return_o <= 1'b0;
        end else begin
            wdt_clear_o <= go && (kind == LCD_K_WDT || kind == LCD_K_SLEEP);
            presc_clear_o <= file_we && (f_addr == `LCD_ADDR_TIMER0) &&
                             ctrl_q[`LCD_CTRL_PSA_T0];
            irq_return_o <= go && (kind == LCD_K_IRQRET);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait cycle, every address acknowledged
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // control and page registers, low byte lane only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `LCD_CTRL_RST;
            page_q <= `LCD_PAGE_RST;
        end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `LCD_REG_CTRL) begin
                ctrl_q <= wb_dat_i[1:0];
            end
            if (wb_adr_i == `LCD_REG_PAGE) begin
                page_q <= wb_dat_i[4:0];
            end
        end
    end

    // read data registered with the acknowledge, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `LCD_REG_CTRL: wb_dat_o <= {30'h0, ctrl_q};
                `LCD_REG_STATUS: wb_dat_o <= {18'h0, standby_o, powerdown_q, timeout_q, z_q,
                                             digit_q, c_q, w_q};
                `LCD_REG_PC: wb_dat_o <= {19'h0, pc_o};
                `LCD_REG_PAGE: wb_dat_o <= {27'h0, page_q};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ---- dv/lcd_core_sva.sv ----
// port-level checker for the decoder core
`timescale 1ns/100ps
`include "lcd_consts.svh"
module lcd_core_sva #(
    parameter int STACK_DEPTH = 8,
    parameter int FILE_WORDS = 128
) (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // sync reset
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_we_i, // bus write
    input wire logic [7:0] wb_adr_i, // bus address
    input wire logic [31:0] wb_dat_i, // bus write data
    input wire logic [31:0] wb_dat_o, // bus read data
    input wire logic wb_ack_o, // bus acknowledge
    input wire logic [12:0] pc_o, // program counter
    input wire logic [7:0] port_latch_o, // port latch
    input wire logic standby_o, // standby level
    input wire logic wdt_clear_o, // watchdog clear pulse
    input wire logic irq_return_o // interrupt return pulse
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a request is taken only while ack is low
    sequence wb_take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence rd_take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
    endsequence
    // a non-sequential pc move means a branch was taken
    sequence pc_jump_s;
        $changed(pc_o) && (pc_o != $past(pc_o) + 13'h1);
    endsequence

    ////////////////////////////////////////////////////////////////
    ack_delay_a: assert property (wb_take_s |=> wb_ack_o)
        else $error("ack not one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    unmap_read_a: assert property (rd_take_s ##0 !(wb_adr_i inside {`LCD_REG_CTRL,
        `LCD_REG_STATUS, `LCD_REG_PC, `LCD_REG_PAGE}) |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    pc_read_a: assert property (rd_take_s ##0 wb_adr_i == `LCD_REG_PC
        |=> wb_dat_o == {19'h0, $past(pc_o)})
        else $error("pc register read mismatch");
    dummy_hold_a: assert property (pc_jump_s |=> $stable(pc_o))
        else $error("no dummy cycle after branch");
    standby_wdt_a: assert property ($rose(standby_o) |-> wdt_clear_o)
        else $error("standby entry without watchdog clear");
    standby_pc_a: assert property (standby_o && $past(standby_o) |-> $stable(pc_o))
        else $error("pc moved in standby");
    wake_ctrl_a: assert property ($fell(standby_o) |-> wb_ack_o
        && $past(wb_we_i && wb_adr_i == `LCD_REG_CTRL && wb_dat_i[2]))
        else $error("standby left without wake write");
    irq_ret_a: assert property (irq_return_o |=> !irq_return_o && $stable(pc_o))
        else $error("interrupt return pulse or dummy wrong");
    reset_state_a: assert property (disable iff (1'b0) rst_i |=> pc_o == 13'h0
        && port_latch_o == 8'h0 && !standby_o && !wb_ack_o)
        else $error("reset state wrong");
endmodule

bind lcd_core lcd_core_sva #(.STACK_DEPTH(STACK_DEPTH), .FILE_WORDS(FILE_WORDS)) u_sva (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .pc_o, .port_latch_o, .standby_o, .wdt_clear_o, .irq_return_o
);

// ---- dv/lcd_core_tb.sv ----
// self-checking bench for the literal and control decoder
`timescale 1ns/100ps
`include "lcd_consts.svh"
module lcd_core_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [13:0] instr_i = 14'h0;
    logic instr_valid_i = 1'b0;
    logic [7:0] port_pins_i = 8'h00;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, standby_o, wdt_clear_o, presc_clear_o, irq_return_o;
    logic [12:0] pc_o;
    logic [7:0] port_latch_o;
    int mismatches = 0;
    int compares = 0;
    int n_wdt = 0;
    int n_presc = 0;
    int n_irq = 0;

    lcd_core dut (.clk_i, .rst_i, .instr_i, .instr_valid_i, .port_pins_i, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
        .pc_o, .port_latch_o, .standby_o, .wdt_clear_o, .presc_clear_o, .irq_return_o);

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    // strobes are counted so a test can look after they have gone
    always @(posedge clk_i) begin
        n_wdt <= n_wdt + wdt_clear_o;
        n_presc <= n_presc + presc_clear_o;
        n_irq <= n_irq + irq_return_o;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // classic single wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'h1;
        // no cycle count is assumed; only the watchdog ends a hang
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic st(input logic [13:0] e);
        wb(1'b0, `LCD_REG_STATUS, 32'h0);
        chk(rd, {18'h0, e});
    endtask

    // one word; with trap a jump to zero sits on the bus in the dummy cycle
    task automatic exec(input logic [13:0] w, input bit trap);
        @(posedge clk_i);
        instr_i <= w;
        instr_valid_i <= 1'b1;
        @(posedge clk_i);
        instr_i <= 14'h2800;
        instr_valid_i <= trap;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        @(negedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        wb(1'b0, `LCD_REG_CTRL, 32'h0);
        chk(rd, 32'h0);
        st(14'h1800);
        wb(1'b1, `LCD_REG_PAGE, 32'hffff_ffff);
        wb(1'b0, `LCD_REG_PAGE, 32'h0);
        chk(rd, 32'h1f);
        // status is read-only, unmapped writes vanish
        wb(1'b1, `LCD_REG_STATUS, 32'hffff);
        st(14'h1800);
        wb(1'b1, 8'h10, 32'hff);
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        $display("register test done");
    endtask

    task automatic t_lit;
        logic [13:0] w [9] = '{14'h30fe, 14'h390f, 14'h38f1, 14'h3aff, 14'h3fff,
            14'h3e01, 14'h3301, 14'h3c10, 14'h3d00};
        logic [13:0] s [9] = '{14'h18fe, 14'h180e, 14'h18ff, 14'h1c00, 14'h18ff,
            14'h1f00, 14'h1f01, 14'h190f, 14'h18f1};
        wb(1'b1, `LCD_REG_CTRL, 32'h1);
        for (int i = 0; i < 9; i++) begin
            exec(w[i], 1'b0);
            st(s[i]);
        end
        $display("literal test done");
    endtask

    task automatic t_flow;
        int c;
        exec(14'h2923, 1'b1);
        chk(pc_o, 13'h1923);
        wb(1'b0, `LCD_REG_PC, 32'h0);
        chk(rd, 32'h1923);
        exec(14'h2055, 1'b1);
        chk(pc_o, 13'h1855);
        exec(14'h345a, 1'b1);
        chk(pc_o, 13'h1924);
        st(14'h185a);
        exec(14'h2200, 1'b1);
        exec(14'h0008, 1'b1);
        chk(pc_o, 13'h1925);
        exec(14'h2010, 1'b1);
        c = n_irq;
        exec(14'h0009, 1'b1);
        chk(pc_o, 13'h1926);
        chk(n_irq - c, 1);
        st(14'h185a);
        $display("flow test done");
    endtask

    task automatic t_file;
        int c;
        // results must come from the pins, never from the latch
        for (int b = 0; b < 8; b++) begin
            @(posedge clk_i) port_pins_i <= 8'h00;
            exec(14'h1406 | 14'(b << 7), 1'b0);
            chk(port_latch_o, 8'h01 << b);
            @(posedge clk_i) port_pins_i <= 8'hff;
            exec(14'h1006 | 14'(b << 7), 1'b0);
            chk(port_latch_o, 8'(~(8'h01 << b)));
        end
        st(14'h185a);
        exec(14'h30d0, 1'b0);
        @(posedge clk_i) port_pins_i <= 8'h3b;
        exec(14'h0706, 1'b0);
        st(14'h190b);
        exec(14'h0786, 1'b0);
        chk(port_latch_o, 8'h46);
        st(14'h1a0b);
        // timer zero file content is unknown, so its flags are not judged later
        wb(1'b1, `LCD_REG_CTRL, 32'h3);
        c = n_presc;
        exec(14'h1401, 1'b0);
        chk(n_presc - c, 1);
        exec(14'h0701, 1'b0);
        wb(1'b1, `LCD_REG_CTRL, 32'h1);
        exec(14'h1401, 1'b0);
        chk(n_presc - c, 1);
        $display("file test done");
    endtask

    task automatic t_ctl;
        int c;
        logic [12:0] p;
        c = n_wdt;
        exec(14'h0063, 1'b0);
        chk(standby_o, 1'b1);
        chk(n_wdt - c, 1);
        wb(1'b0, `LCD_REG_STATUS, 32'h0);
        chk(rd[13:11], 3'b101);
        p = pc_o;
        exec(14'h2800, 1'b0);
        chk(pc_o, p);
        wb(1'b1, `LCD_REG_CTRL, 32'h5);
        chk(standby_o, 1'b0);
        exec(14'h0064, 1'b0);
        chk(n_wdt - c, 2);
        wb(1'b0, `LCD_REG_STATUS, 32'h0);
        chk(rd[13:11], 3'b011);
        $display("control test done");
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_lit;
        t_flow;
        t_file;
        t_ctl;
        give_verdict;
    end

    // the tests need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk_i);
        mismatches++;
        give_verdict;
    end
endmodule
